/* File: hw/eag_core.sv */
/*
  Effective address generator top: forms the 20-bit effective address
  per instruction addressing mode, holds the index registers and their
  bank fields, applies post-modify and specialised immediate effects.
  Assumes the sequencer presents one decoded request per start pulse
  and the bus interface performs the memory access.
*/
// Behaviour
// - Address is bank nibble above 16-bit address
// - Bank crossing moves result bank; fields kept except the first index bank in post-modify
// - Immediate address is the argument location
// - Add-immediate sign extends byte to 16
// - Multiply-accumulate byte gives two signed steps
// - Push/pull multiple byte is register mask
// - Absolute mode: extended bank above word
// - Long absolute only for jump or call
// - Short indexed adds unsigned byte offset
// - Word indexed adds signed word offset
// - Long indexed adds signed 20-bit, jump/call
// - Implied mode performs no operand fetch
// - Accumulator offset sign extends secondary accumulator
// - Taken branch adds offset to program location
// - Post-modify uses first index, then adds
// - Third index and bank loaded at reset
// - Lowest 512 bytes of bank 0 reserved
module eag_core
  import eag_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [12:0] mode,
  input  wire logic [2:0]  special_op,
  input  wire logic [1:0]  add_target,
  input  wire logic        jump_or_call,
  input  wire logic        branch_taken,
  input  wire logic [1:0]  index_sel,
  input  wire logic [23:0] operand,
  input  wire logic [15:0] program_counter,
  input  wire logic [3:0]  program_bank,
  input  wire logic [15:0] arg_pointer,
  input  wire logic [3:0]  extended_bank_field,
  input  wire logic [15:0] secondary_accum,
  input  wire logic [15:0] double_accum,
  input  wire logic [15:0] stack_pointer,
  input  wire logic        load_index,
  input  wire logic [1:0]  load_sel,
  input  wire logic [19:0] load_value,
  output logic      [19:0] eff_addr,
  output logic             addr_valid,
  output logic             mem_fetch,
  output logic             mode_error,
  output logic             vector_hit,
  output logic      [7:0]  reg_mask,
  output logic             mask_valid,
  output logic      [15:0] add_result,
  output logic      [1:0]  add_result_target,
  output logic             add_valid,
  output logic      [15:0] index_one,
  output logic      [15:0] index_two,
  output logic      [15:0] index_three,
  output logic      [3:0]  index_one_bank,
  output logic      [3:0]  index_two_bank,
  output logic      [3:0]  index_three_bank
);

  // Whole module state: one copy is computed, one is registered.
  // Index registers live here, so bank fields change only on a load
  // or a post-modify step.
  typedef struct packed {
    eag_state_e  state;
    logic [19:0] eff_addr;
    logic        addr_valid;
    logic        mem_fetch;
    logic        mode_error;
    logic        vector_hit;
    logic [7:0]  reg_mask;
    logic        mask_valid;
    logic [15:0] add_result;
    logic [1:0]  add_result_target;
    logic        add_valid;
    logic [7:0]  post_ofs;
    logic [15:0] ix1;
    logic [15:0] ix2;
    logic [15:0] ix3;
    logic [3:0]  bk1;
    logic [3:0]  bk2;
    logic [3:0]  bk3;
  } eag_state_s;

  eag_state_s r;
  eag_state_s next_r;

  // Combinational helpers feeding the mode decode
  logic [15:0] sel_index;
  logic [3:0]  sel_bank;
  logic [19:0] idx_offset;
  logic [19:0] idx_sum;
  logic [19:0] br_offset;
  logic [19:0] br_sum;
  logic [19:0] post_sum;
  logic [15:0] step_one;
  logic [15:0] step_two;

  // Index register picked by the instruction
  // Select code 3 is unused and falls back to the first index
  always_comb begin
    case (index_sel)
      EAG_SEL_TWO: begin
        sel_index = r.ix2;
        sel_bank  = r.bk2;
      end
      EAG_SEL_THREE: begin
        sel_index = r.ix3;
        sel_bank  = r.bk3;
      end
      default: begin
        sel_index = r.ix1;
        sel_bank  = r.bk1;
      end
    endcase
  end

  // Offset added to the selected index for each indexed mode
  // Long offset is taken as 20 bits; the top four operand bits are dropped
  always_comb begin
    case (mode)
      EAG_M_SHORT_IDX: idx_offset = {12'h000, operand[7:0]};
      EAG_M_WORD_IDX:
        idx_offset = {{4{operand[15]}}, operand[15:0]};
      EAG_M_LONG_IDX:  idx_offset = operand[19:0];
      EAG_M_ACC_OFS:
        idx_offset = {{4{secondary_accum[15]}}, secondary_accum};
      default:         idx_offset = 20'h00000;
    endcase
  end

  // Branch displacement, byte or word, sign extended
  // Only the short form looks at the low byte alone
  always_comb begin
    if (mode == EAG_M_SHORT_BR) begin
      br_offset = {{12{operand[7]}}, operand[7:0]};
    end else begin
      br_offset = {{4{operand[15]}}, operand[15:0]};
    end
  end

  eag_bank_add u_idx_add (
    .bank   (sel_bank),
    .base   (sel_index),
    .offset (idx_offset),
    .sum    (idx_sum)
  );

  eag_bank_add u_br_add (
    .bank   (program_bank),
    .base   (program_counter),
    .offset (br_offset),
    .sum    (br_sum)
  );

  // Post-modify works on the first index with its bank
  eag_bank_add u_post_add (
    .bank   (r.bk1),
    .base   (r.ix1),
    .offset ({{12{r.post_ofs[7]}}, r.post_ofs}),
    .sum    (post_sum)
  );

  eag_nibble_ext u_step_one (
    .nibble (operand[7:4]),
    .wide   (step_one)
  );

  eag_nibble_ext u_step_two (
    .nibble (operand[3:0]),
    .wide   (step_two)
  );

  // Mode decode and register updates
  always_comb begin
    logic [15:0] imm_ext;
    logic [15:0] add_base;
    imm_ext  = {{8{operand[7]}}, operand[7:0]};
    add_base = 16'h0000;
    next_r = r;
    // Pulses last one cycle; data outputs hold until the next request
    next_r.addr_valid = 1'b0;
    next_r.mask_valid = 1'b0;
    next_r.add_valid  = 1'b0;
    next_r.mode_error = 1'b0;
    case (r.state)
      EAG_ST_IDLE: begin
        if (start) begin
          next_r.addr_valid = 1'b1;
          next_r.mem_fetch  = 1'b1;
          // Each mode puts a bank nibble above a 16-bit address
          case (mode)
            EAG_M_BYTE_IMM, EAG_M_WORD_IMM: begin
              next_r.eff_addr = {program_bank, arg_pointer};
            end
            EAG_M_SPECIAL_IMM: begin
              next_r.eff_addr  = {program_bank, arg_pointer};
              next_r.mem_fetch = 1'b0;
              case (special_op)
                EAG_OP_ADD_IMM: begin
                  // Sum goes back to the sequencer, which owns the target
                  case (add_target)
                    2'h0: add_base = stack_pointer;
                    2'h1: add_base = sel_index;
                    2'h2: add_base = double_accum;
                    default: add_base = secondary_accum;
                  endcase
                  next_r.add_result = 16'(add_base + imm_ext);
                  next_r.add_result_target = add_target;
                  next_r.add_valid  = 1'b1;
                end
                EAG_OP_MAC, EAG_OP_REPEAT_MULTIPLY_OP: begin
                  next_r.ix1 = 16'(r.ix1 + step_one);
                  next_r.ix2 = 16'(r.ix2 + step_two);
                end
                EAG_OP_PUSH_M, EAG_OP_PULL_M: begin
                  next_r.reg_mask   = operand[7:0];
                  next_r.mask_valid = 1'b1;
                end
                default: begin
                  next_r.mode_error = 1'b1;
                end
              endcase
            end
            EAG_M_ABS: begin
              next_r.eff_addr =
                {extended_bank_field, operand[15:0]};
            end
            EAG_M_LONG_ABS: begin
              // Top four bits of the 24-bit field are padding
              next_r.eff_addr  = operand[19:0];
              next_r.mem_fetch = 1'b0;
              if (!jump_or_call) begin
                next_r.mode_error = 1'b1;
                next_r.addr_valid = 1'b0;
              end
            end
            EAG_M_SHORT_IDX, EAG_M_WORD_IDX, EAG_M_ACC_OFS: begin
              next_r.eff_addr = idx_sum;
            end
            EAG_M_LONG_IDX: begin
              // Jump or call target only; no operand fetch
              next_r.eff_addr  = idx_sum;
              next_r.mem_fetch = 1'b0;
              if (!jump_or_call) begin
                next_r.mode_error = 1'b1;
                next_r.addr_valid = 1'b0;
              end
            end
            EAG_M_IMPLIED: begin
              // Operands are processor resources; nothing is read
              next_r.eff_addr   = 20'h00000;
              next_r.mem_fetch  = 1'b0;
              next_r.addr_valid = 1'b0;
            end
            EAG_M_SHORT_BR, EAG_M_LONG_BR: begin
              // Target is a new program location; no operand read
              next_r.mem_fetch = 1'b0;
              if (branch_taken) begin
                next_r.eff_addr = br_sum;
              end else begin
                next_r.addr_valid = 1'b0;
              end
            end
            EAG_M_POST_MOD: begin
              next_r.eff_addr = {r.bk1, r.ix1};
              next_r.post_ofs = operand[7:0];
              next_r.state    = EAG_ST_POST;
            end
            default: begin
              next_r.mode_error = 1'b1;
              next_r.addr_valid = 1'b0;
              next_r.mem_fetch  = 1'b0;
            end
          endcase
          // Data access into the vector area is flagged
          next_r.vector_hit = next_r.addr_valid && next_r.mem_fetch &&
                              (next_r.eff_addr < EAG_VEC_LIMIT);
        end
      end
      EAG_ST_POST: begin
        // Index stepped only after its address went out
        // A start in this cycle is ignored; one gap cycle is needed
        {next_r.bk1, next_r.ix1} = post_sum;
        next_r.state = EAG_ST_IDLE;
      end
      default: begin
        next_r.state = EAG_ST_IDLE;
      end
    endcase
    // Sequencer load of an index; bank fields change only here and in the post-modify step
    // Dropped during the post-modify step so that step is never lost
    if (load_index && r.state == EAG_ST_IDLE) begin
      case (load_sel)
        EAG_SEL_TWO:   {next_r.bk2, next_r.ix2} = load_value;
        EAG_SEL_THREE: {next_r.bk3, next_r.ix3} = load_value;
        default:       {next_r.bk1, next_r.ix1} = load_value;
      endcase
    end
  end

  // State register; third index preset at reset
  // State goes idle, other fields clear to zero, so no pulse shows during reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r       <= '0;
      r.state <= EAG_ST_IDLE;
      r.ix3   <= EAG_RST_INDEX_THREE;
      r.bk3   <= EAG_RST_INDEX_THREE_BANK;
    end else begin
      r <= next_r;
    end
  end

  // Every output is a field of the state register
  assign eff_addr          = r.eff_addr;
  assign addr_valid        = r.addr_valid;
  assign mem_fetch         = r.mem_fetch;
  assign mode_error        = r.mode_error;
  assign vector_hit        = r.vector_hit;

  // Specialised immediate answers
  assign reg_mask          = r.reg_mask;
  assign mask_valid        = r.mask_valid;
  assign add_result        = r.add_result;
  assign add_result_target = r.add_result_target;
  assign add_valid         = r.add_valid;

  // Index registers as the sequencer sees them
  assign index_one         = r.ix1;
  assign index_two         = r.ix2;
  assign index_three       = r.ix3;
  assign index_one_bank    = r.bk1;
  assign index_two_bank    = r.bk2;
  assign index_three_bank  = r.bk3;

endmodule : eag_core

/* File: hw/eag_pkg.sv */
/*
  Package for the effective address generator: mode codes, register
  selects, widths and reset values shared by all its files.
  Assumes a 20-bit byte address space split into 64-Kbyte banks.
*/
package eag_pkg;

  localparam int EAG_AW   = 20;
  localparam int EAG_BW   = 4;
  localparam int EAG_WW   = 16;

  // Address modes, one-hot coded on the mode input
  localparam logic [12:0] EAG_M_BYTE_IMM   = 13'h0001;
  localparam logic [12:0] EAG_M_WORD_IMM   = 13'h0002;
  localparam logic [12:0] EAG_M_ABS        = 13'h0004;
  localparam logic [12:0] EAG_M_LONG_ABS   = 13'h0008;
  localparam logic [12:0] EAG_M_SHORT_IDX  = 13'h0010;
  localparam logic [12:0] EAG_M_WORD_IDX   = 13'h0020;
  localparam logic [12:0] EAG_M_LONG_IDX   = 13'h0040;
  localparam logic [12:0] EAG_M_IMPLIED    = 13'h0080;
  localparam logic [12:0] EAG_M_ACC_OFS    = 13'h0100;
  localparam logic [12:0] EAG_M_SHORT_BR   = 13'h0200;
  localparam logic [12:0] EAG_M_LONG_BR    = 13'h0400;
  localparam logic [12:0] EAG_M_POST_MOD   = 13'h0800;
  localparam logic [12:0] EAG_M_SPECIAL_IMM = 13'h1000;

  // Specialised byte-immediate operations
  localparam logic [2:0] EAG_OP_NONE      = 3'h0;
  localparam logic [2:0] EAG_OP_ADD_IMM   = 3'h1;
  localparam logic [2:0] EAG_OP_MAC       = 3'h2;
  localparam logic [2:0] EAG_OP_REPEAT_MULTIPLY_OP      = 3'h3;
  localparam logic [2:0] EAG_OP_PUSH_M    = 3'h4;
  localparam logic [2:0] EAG_OP_PULL_M    = 3'h5;

  // Index register select
  localparam logic [1:0] EAG_SEL_ONE   = 2'h0;
  localparam logic [1:0] EAG_SEL_TWO   = 2'h1;
  localparam logic [1:0] EAG_SEL_THREE = 2'h2;

  // Exception vector area: lowest bytes of bank 0
  localparam logic [19:0] EAG_VEC_LIMIT = 20'h00200;

  // Reset values of the third index register and its bank
  localparam logic [15:0] EAG_RST_INDEX_THREE = 16'h0000;
  localparam logic [3:0]  EAG_RST_INDEX_THREE_BANK = 4'h0;

  // Sequencer states
  typedef enum logic [1:0] {
    EAG_ST_IDLE = 2'b01,
    EAG_ST_POST = 2'b10
  } eag_state_e;

endpackage : eag_pkg

/* File: hw/eag_bank_add.sv */
/*
  Adder forming bank:address plus a 20-bit offset, modulo 2^20.
  Assumes offsets arrive already sign or zero extended to 20 bits.
*/
module eag_bank_add
  import eag_pkg::*;
(
  input  wire logic [3:0]  bank,
  input  wire logic [15:0] base,
  input  wire logic [19:0] offset,
  output logic      [19:0] sum
);

  // Carry out of bit 19 dropped; bank bits move on crossing
  always_comb begin
    sum = 20'({bank, base} + offset);
  end

endmodule : eag_bank_add

/* File: hw/eag_nibble_ext.sv */
/*
  Sign extender for one signed 4-bit step to 16 bits.
  Assumes the nibble is two's complement.
*/
module eag_nibble_ext
  import eag_pkg::*;
(
  input  wire logic [3:0]  nibble,
  output logic      [15:0] wide
);

  // Two step offsets share one immediate byte
  always_comb begin
    wide = {{12{nibble[3]}}, nibble};
  end

endmodule : eag_nibble_ext

/* File: verification/eag_core_asserts.sv */
/*
  Checker for eag_core: address forming, refusals and post-modify.
  Assumes it is bound to eag_core, one clock, rst active high.
*/
module eag_core_asserts
  import eag_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        start,
  input wire logic [12:0] mode,
  input wire logic [2:0]  special_op,
  input wire logic        jump_or_call,
  input wire logic        branch_taken,
  input wire logic [1:0]  index_sel,
  input wire logic [23:0] operand,
  input wire logic [15:0] program_counter,
  input wire logic [3:0]  program_bank,
  input wire logic [3:0]  extended_bank_field,
  input wire logic [19:0] eff_addr,
  input wire logic        addr_valid,
  input wire logic        mem_fetch,
  input wire logic        mode_error,
  input wire logic [7:0]  reg_mask,
  input wire logic        mask_valid,
  input wire logic [15:0] index_one,
  input wire logic [15:0] index_two,
  input wire logic [3:0]  index_one_bank,
  input wire logic [3:0]  index_two_bank,
  input wire logic [15:0] secondary_accum,
  input wire logic        vector_hit
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [23:0] op_q;
  logic [23:0] op_q2;
  wire  [19:0] ix1 = {index_one_bank, index_one};
  wire  [19:0] ix2 = {index_two_bank, index_two};
  wire  [19:0] pcx = {program_bank, program_counter};
  wire  [19:0] e_ext = {{4{secondary_accum[15]}}, secondary_accum};

  // Operand copies line up with answers one and two cycles later
  always_ff @(posedge clk) begin
    op_q  <= operand;
    op_q2 <= op_q;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Post-modify steps: request, address use, then index step
  sequence s_post_req;
    start && mode == EAG_M_POST_MOD;
  endsequence
  sequence s_post_use;
    addr_valid && eff_addr == $past(ix1);
  endsequence

  AST_SHORT_IDX: assert property (
    start && mode == EAG_M_SHORT_IDX && index_sel == EAG_SEL_ONE |=>
    addr_valid && eff_addr == $past(ix1) + {12'h000, op_q[7:0]})
    else $error("short indexed address wrong");
  AST_WORD_IDX: assert property (
    start && mode == EAG_M_WORD_IDX && index_sel == EAG_SEL_TWO |=>
    eff_addr == $past(ix2) + {{4{op_q[15]}}, op_q[15:0]})
    else $error("word indexed address wrong");
  AST_ABS: assert property (
    start && mode == EAG_M_ABS |=>
    eff_addr == {$past(extended_bank_field), op_q[15:0]})
    else $error("absolute address wrong");
  AST_LONG_REFUSE: assert property (
    start && (mode == EAG_M_LONG_ABS || mode == EAG_M_LONG_IDX) &&
    !jump_or_call |=> mode_error && !addr_valid)
    else $error("long mode accepted without jump or call");
  AST_IMPLIED: assert property (
    start && mode == EAG_M_IMPLIED |=> !addr_valid && !mem_fetch)
    else $error("implied mode fetched");
  AST_BRANCH: assert property (
    start && mode == EAG_M_SHORT_BR && branch_taken |=>
    addr_valid && eff_addr == $past(pcx) + {{12{op_q[7]}}, op_q[7:0]})
    else $error("branch target wrong");
  AST_POST_MOD: assert property (
    s_post_req |=> s_post_use ##1
    ix1 == $past(ix1, 2) + {{12{op_q2[7]}}, op_q2[7:0]})
    else $error("post-modify wrong");
  AST_MASK: assert property (
    start && mode == EAG_M_SPECIAL_IMM && (special_op == EAG_OP_PUSH_M ||
    special_op == EAG_OP_PULL_M) |=> mask_valid && reg_mask == op_q[7:0])
    else $error("register mask wrong");
  AST_ACC_OFS: assert property (
    start && mode == EAG_M_ACC_OFS && index_sel == EAG_SEL_ONE |=>
    addr_valid && eff_addr == $past(ix1) + $past(e_ext))
    else $error("accumulator offset address wrong");
  AST_VECTOR: assert property (
    start && mode == EAG_M_ABS |=>
    vector_hit == (eff_addr < EAG_VEC_LIMIT))
    else $error("vector area flag wrong");
endmodule : eag_core_asserts

bind eag_core eag_core_asserts i_eag_core_asserts (.*);

/* File: verification/eag_seq_model.sv */
/*
  Sequencer model facing eag_core: holds processor resources and
  issues one decoded request per call, changed at the falling edge.
  Assumes a free-running clk from the bench.
*/
module eag_seq_model
  import eag_pkg::*;
(
  input  wire logic clk,
  output logic        start,
  output logic [12:0] mode,
  output logic [2:0]  special_op,
  output logic [1:0]  add_target,
  output logic        jump_or_call,
  output logic        branch_taken,
  output logic [1:0]  index_sel,
  output logic [23:0] operand,
  output logic [15:0] program_counter,
  output logic [3:0]  program_bank,
  output logic [15:0] arg_pointer,
  output logic [3:0]  extended_bank_field,
  output logic [15:0] secondary_accum,
  output logic [15:0] double_accum,
  output logic [15:0] stack_pointer,
  output logic        load_index,
  output logic [1:0]  load_sel,
  output logic [19:0] load_value
);
  timeunit 1ns;
  timeprecision 1ps;

  // Resources stay fixed; bench expectations are built on them
  initial begin
    {start, load_index, jump_or_call, branch_taken} = 4'h0;
    {special_op, add_target, index_sel, load_sel} = 9'h000;
    mode = EAG_M_IMPLIED;
    operand = 24'h000000;
    load_value = 20'h00000;
    program_counter = 16'hFFC0;
    program_bank = 4'h2;
    arg_pointer = 16'h1234;
    extended_bank_field = 4'h0;
    secondary_accum = 16'h8000;
    double_accum = 16'h7FF0;
    stack_pointer = 16'h0100;
  end

  // One request, start held for exactly one rising edge
  task automatic issue(input logic [12:0] m, input logic [23:0] op,
                       input logic [1:0] s, input logic [6:0] x);
    @(negedge clk);
    {special_op, add_target, jump_or_call, branch_taken} = x;
    mode = m;
    operand = op;
    index_sel = s;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask : issue

  // Index load while idle
  task automatic load(input logic [1:0] s, input logic [19:0] v);
    @(negedge clk);
    load_sel = s;
    load_value = v;
    load_index = 1'b1;
    @(negedge clk);
    load_index = 1'b0;
  endtask : load
endmodule : eag_seq_model

/* File: verification/tb_eag_core.sv */
/*
  Bench for eag_core: one task per addressing scenario, outputs
  judged at the falling edge. Assumes eag_seq_model drives inputs.
*/
module tb_eag_core
  import eag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start, jump_or_call, branch_taken, load_index, addr_valid;
  logic mem_fetch, mode_error, vector_hit, mask_valid, add_valid;
  logic [12:0] mode;
  logic [2:0] special_op;
  logic [1:0] add_target, index_sel, load_sel, add_result_target;
  logic [23:0] operand;
  logic [15:0] program_counter, arg_pointer, secondary_accum, double_accum;
  logic [15:0] stack_pointer, add_result, index_one, index_two, index_three;
  logic [3:0] program_bank, extended_bank_field, index_one_bank;
  logic [3:0] index_two_bank, index_three_bank;
  logic [19:0] load_value, eff_addr, ea;
  logic [7:0] reg_mask;
  logic av, me, mv, dv;
  int fail_count = 0;
  int checks_done = 0;

  eag_core i_eag_core (.*);
  eag_seq_model i_eag_seq_model (.*);

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic chk(input string n, input logic [19:0] s, e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Issue, then watch three cycles so a one-cycle pulse is not missed
  task automatic run(input logic [12:0] m, input logic [23:0] op,
                     input logic [1:0] s, input logic [6:0] x);
    {av, me, mv, dv} = 4'h0;
    i_eag_seq_model.issue(m, op, s, x);
    repeat (3) begin
      if (addr_valid === 1'b1) begin
        av = 1'b1;
        ea = eff_addr;
      end
      me |= (mode_error === 1'b1);
      mv |= (mask_valid === 1'b1);
      dv |= (add_valid === 1'b1);
      @(negedge clk);
    end
  endtask : run

  task automatic sc_indexed();
    chk("rst_z", {index_three_bank, index_three}, {EAG_RST_INDEX_THREE_BANK,
        EAG_RST_INDEX_THREE});
    i_eag_seq_model.load(EAG_SEL_ONE, 20'h3FFF0);
    run(EAG_M_SHORT_IDX, 24'h000020, EAG_SEL_ONE, 7'h00);
    chk("short_av", av, 1'b1);
    chk("short", ea, 20'h40010);
    chk("bank_kept", index_one_bank, 4'h3);
    i_eag_seq_model.load(EAG_SEL_TWO, 20'h50010);
    run(EAG_M_WORD_IDX, 24'h00FFE0, EAG_SEL_TWO, 7'h00);
    chk("word", ea, 20'h4FFF0);
    chk("bank_two", {index_two_bank, index_two}, 20'h50010);
    i_eag_seq_model.load(EAG_SEL_THREE, 20'hFFFF0);
    run(EAG_M_LONG_IDX, 24'h000020, EAG_SEL_THREE, 7'h02);
    chk("long", ea, 20'h00010);
    chk("bank_three", index_three_bank, 4'hF);
    run(EAG_M_LONG_IDX, 24'h000020, EAG_SEL_THREE, 7'h00);
    chk("long_err", {me, av}, 2'b10);
  endtask : sc_indexed

  task automatic sc_absolute();
    run(EAG_M_ABS, 24'h0001FE, EAG_SEL_ONE, 7'h00);
    chk("abs", ea, 20'h001FE);
    chk("abs_fetch", mem_fetch, 1'b1);
    chk("vec_in", vector_hit, 1'b1);
    run(EAG_M_ABS, 24'h000200, EAG_SEL_ONE, 7'h00);
    chk("vec_out", vector_hit, 1'b0);
    run(EAG_M_LONG_ABS, 24'h0ABCDE, EAG_SEL_ONE, 7'h02);
    chk("labs", ea, 20'hABCDE);
    run(EAG_M_LONG_ABS, 24'h0ABCDE, EAG_SEL_ONE, 7'h00);
    chk("labs_err", {me, av}, 2'b10);
    run(EAG_M_BYTE_IMM, 24'h000000, EAG_SEL_ONE, 7'h00);
    chk("byte_immediate_mode", ea, 20'h21234);
    run(EAG_M_WORD_IMM, 24'h000000, EAG_SEL_ONE, 7'h00);
    chk("word_immediate_mode", ea, 20'h21234);
    run(EAG_M_IMPLIED, 24'h000000, EAG_SEL_ONE, 7'h00);
    chk("inh", {av, mem_fetch}, 2'b00);
  endtask : sc_absolute

  task automatic sc_flow();
    i_eag_seq_model.load(EAG_SEL_ONE, 20'h30010);
    run(EAG_M_ACC_OFS, 24'h000000, EAG_SEL_ONE, 7'h00);
    chk("acc", ea, 20'h28010);
    run(EAG_M_SHORT_BR, 24'h000080, EAG_SEL_ONE, 7'h01);
    chk("br8", ea, 20'h2FF40);
    run(EAG_M_LONG_BR, 24'h000080, EAG_SEL_ONE, 7'h01);
    chk("br16", ea, 20'h30040);
    run(EAG_M_SHORT_BR, 24'h000080, EAG_SEL_ONE, 7'h00);
    chk("br_not", av, 1'b0);
    i_eag_seq_model.load(EAG_SEL_ONE, 20'h10001);
    run(EAG_M_POST_MOD, 24'h0000FE, EAG_SEL_ONE, 7'h00);
    chk("post_use", ea, 20'h10001);
    chk("post_step", {index_one_bank, index_one}, 20'h0FFFF);
  endtask : sc_flow

  task automatic sc_special();
    logic [15:0] exp [4] = '{16'h0080, 16'h0180, 16'h7F70, 16'h7F80};
    i_eag_seq_model.load(EAG_SEL_ONE, 20'h10200);
    i_eag_seq_model.load(EAG_SEL_TWO, 20'h20100);
    for (int t = 0; t < 4; t++) begin
      run(EAG_M_SPECIAL_IMM, 24'h000080, EAG_SEL_ONE,
          {EAG_OP_ADD_IMM, t[1:0], 2'b00});
      chk("add", {dv, add_result_target, add_result},
          {1'b1, t[1:0], exp[t]});
    end
    run(EAG_M_SPECIAL_IMM, 24'h00007F, EAG_SEL_ONE, {EAG_OP_MAC, 4'h0});
    run(EAG_M_SPECIAL_IMM, 24'h00007F, EAG_SEL_ONE, {EAG_OP_REPEAT_MULTIPLY_OP, 4'h0});
    chk("mac_one", index_one, 16'h020E);
    chk("mac_two", index_two, 16'h00FE);
    for (int k = 0; k < 2; k++) begin
      run(EAG_M_SPECIAL_IMM, 24'h0000A5, EAG_SEL_ONE,
          {k ? EAG_OP_PULL_M : EAG_OP_PUSH_M, 4'h0});
      chk("mask", {mv, reg_mask}, {1'b1, 8'hA5});
    end
  endtask : sc_special

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // Reset for five cycles, then the scenarios
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    sc_indexed();
    sc_absolute();
    sc_flow();
    sc_special();
    give_verdict();
  end
endmodule : tb_eag_core
